// ### hdl/mark_ref_cfg.svh
// constants for the mark-period reference timing block
// assumes a single 50 MHz system clock; the crystal rate is derived from it
`ifndef MARK_REF_CFG_SVH
`define MARK_REF_CFG_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define CNT_W        25
`define FREQ_W       13
`define LATCH_W      48
`define STATUS_W     8
`define STEP_W       4

// ----------------------------------------------------------------------
// values
// ----------------------------------------------------------------------
`define CNT_OVERFLOW 25'h1FF_FFFF
`define STEP_LAST    4'h9
`define STEP_FIRST   4'h0
`define BIT_LAST     6'h2F
`define TAP_16K_BIT  7
`define TAP_8K_BIT   8
`define LOCK_LOW_W   8

// ----------------------------------------------------------------------
// timing: crystal tick from the system clock by fractional accumulation
// ----------------------------------------------------------------------
`define CLOCK_HZ     50000000
`define XTAL_HZ      4096000
`define ACC_W        26
`define ACC_STEP     (26'(`XTAL_HZ))
`define ACC_WRAP     (26'(`CLOCK_HZ))

`endif

// ### hdl/mark_ref_pkg.sv
// types shared by the mark-period reference timing files
// assumes the constants of mark_ref_cfg.svh
package mark_ref_pkg;

	typedef enum logic [0:0] {
		LINK_IDLE  = 1'b0,
		LINK_SHIFT = 1'b1
	} link_state_t;

	// sign and magnitude of one divider tap selection
	typedef logic [2:0] tap_code_t;

endpackage

// ### hdl/inguard_latch.sv
// serial receiver and 48-bit in-guard control latch with status return
// assumes bits arrive synchronous to clock, one per bit_valid after frame_start
`timescale 1ns/1ps
`include "mark_ref_cfg.svh"

module inguard_latch (
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic                   ce,
	input  wire logic                   link_data,
	input  wire logic                   bit_valid,
	input  wire logic                   frame_start,
	input  wire logic [`STATUS_W-1:0]   status_in,
	output logic      [`LATCH_W-1:0]    control_word,
	output logic                        status_out
);

	mark_ref_pkg::link_state_t state;
	mark_ref_pkg::link_state_t next_state;
	logic [`LATCH_W-1:0]  shreg;
	logic [5:0]           bit_count;
	logic [`STATUS_W-1:0] status_sh;

	wire take_bit  = ce && state == mark_ref_pkg::LINK_SHIFT && bit_valid && !frame_start;
	wire last_bit  = take_bit && bit_count == `BIT_LAST;
	wire [`LATCH_W-1:0] next_shreg = {shreg[`LATCH_W-2:0], link_data};

	always_comb begin
		next_state = state;
		case (state)
			mark_ref_pkg::LINK_IDLE: begin
				if (frame_start)
					next_state = mark_ref_pkg::LINK_SHIFT;
			end
			mark_ref_pkg::LINK_SHIFT: begin
				if (last_bit)
					next_state = mark_ref_pkg::LINK_IDLE;
			end
			default: next_state = mark_ref_pkg::LINK_IDLE;
		endcase
	end

	// ----------------------------------------------------------------------
	// receive and transfer
	// ----------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			state     <= mark_ref_pkg::LINK_IDLE;
			shreg     <= '0;
			bit_count <= '0;
		end else if (ce) begin
			state <= next_state;
			if (frame_start)
				bit_count <= '0;
			else if (take_bit) begin
				shreg     <= next_shreg;
				bit_count <= bit_count + 6'h01;
			end
		end
	end

	// control_word moves only on the last bit, never on a partial word
	always_ff @(posedge clock) begin
		if (rst)
			control_word <= '0;
		else if (last_bit)
			control_word <= next_shreg;
	end

	// status goes back one bit per received bit, captured at frame start;
	// the msb is shown at once so the bit seen before each data bit never
	// depends on how far apart the host spaces its bits
	always_ff @(posedge clock) begin
		if (rst) begin
			status_sh  <= '0;
			status_out <= 1'b0;
		end else if (ce) begin
			if (frame_start) begin
				status_out <= status_in[`STATUS_W-1];
				status_sh  <= {status_in[`STATUS_W-2:0], 1'b0};
			end else if (take_bit) begin
				status_out <= status_sh[`STATUS_W-1];
				status_sh  <= {status_sh[`STATUS_W-2:0], 1'b0};
			end
		end
	end

	// ----------------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	AST_LATCH_FULL_WORD: assert property (
		last_bit |=> control_word == $past(next_shreg))
		else $error("control word not loaded from the completed frame");

	AST_LATCH_HOLD: assert property (
		!last_bit |=> $stable(control_word))
		else $error("control word changed before the frame was complete");

	AST_STATUS_RETURN: assert property (
		ce && frame_start |=> status_out == $past(status_in[`STATUS_W-1]))
		else $error("status msb not returned after frame start");

endmodule

// ### hdl/mark_ref_timing.sv
// out-guard timing for the precision amplitude reference
// assumes CLOCK at 50 MHz, all inputs synchronous to it, RST synchronous high
`timescale 1ns/1ps
`include "mark_ref_cfg.svh"

module mark_ref_timing (
	input  wire logic                  CLOCK,
	input  wire logic                  RST,
	input  wire logic                  CE,
	input  wire logic [`CNT_W-1:0]     THRESHOLD,
	input  wire logic                  THRESHOLD_LOAD,
	input  wire logic                  AC_MODE,
	input  wire logic                  POLARITY_NEG,
	input  wire logic                  EXT_REF_SELECT,
	input  wire logic                  EXT_REF,
	input  wire logic                  STEP_TICK,
	input  wire logic                  LINK_DATA,
	input  wire logic                  LINK_BIT_VALID,
	input  wire logic                  LINK_FRAME_START,
	input  wire logic [`STATUS_W-1:0]  STATUS_IN,
	output logic                       PULSE_RESET,
	output logic                       PULSE_SET,
	output logic                       CHOP_MARK,
	output logic                       REF_INVERT,
	output logic [2:0]                 TAP_SELECT,
	output logic [`STEP_W-1:0]         STEP_INDEX,
	output logic                       STEP_CARRY,
	output logic                       QS_STEP_STROBE,
	output logic                       FREQ_REF_16K,
	output logic                       FREQ_REF_8K,
	output logic [`LATCH_W-1:0]        CONTROL_WORD,
	output logic                       LINK_STATUS_OUT
);

	logic [`ACC_W-1:0]  acc;
	logic               xtal_tick;
	logic [`CNT_W-1:0]  count;
	logic [`CNT_W-1:0]  threshold;
	logic [`FREQ_W-1:0] freq_count;
	logic               ext_prev;

	// ----------------------------------------------------------------------
	// crystal tick: 4.096 MHz on average, jitter of one system clock
	// ----------------------------------------------------------------------
	wire [`ACC_W-1:0] acc_sum  = acc + `ACC_STEP;
	wire              acc_over = acc_sum >= `ACC_WRAP;
	wire [`ACC_W-1:0] next_acc = acc_over ? acc_sum - `ACC_WRAP : acc_sum;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			acc       <= '0;
			xtal_tick <= 1'b0;
		end else if (CE) begin
			acc       <= next_acc;
			xtal_tick <= acc_over;
		end
	end

	// ----------------------------------------------------------------------
	// period counter and comparator
	// ----------------------------------------------------------------------
	wire hit_match    = xtal_tick && count == threshold;
	wire hit_overflow = xtal_tick && count == `CNT_OVERFLOW;

	always_ff @(posedge CLOCK) begin
		if (RST)
			threshold <= '0;
		else if (CE && THRESHOLD_LOAD)
			threshold <= THRESHOLD;
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			count <= '0;
		else if (CE && xtal_tick)
			count <= count + 25'h000_0001;
	end

	// when threshold equals overflow the space has zero length, so set wins
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			PULSE_RESET <= 1'b0;
			PULSE_SET   <= 1'b0;
			CHOP_MARK   <= 1'b0;
		end else if (CE) begin
			PULSE_RESET <= hit_match;
			PULSE_SET   <= hit_overflow;
			if (hit_overflow)
				CHOP_MARK <= 1'b1;
			else if (hit_match)
				CHOP_MARK <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// polarity
	// ----------------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RST)
			REF_INVERT <= 1'b0;
		else if (CE)
			REF_INVERT <= !AC_MODE && POLARITY_NEG;
	end

	// ----------------------------------------------------------------------
	// divide-by-ten quasi-sine sequencer
	// ----------------------------------------------------------------------
	function automatic mark_ref_pkg::tap_code_t tap_of(input logic [`STEP_W-1:0] s);
		case (s)
			4'h1, 4'h4: tap_of = 3'h1;
			4'h2, 4'h3: tap_of = 3'h2;
			4'h6, 4'h9: tap_of = 3'h5;
			4'h7, 4'h8: tap_of = 3'h6;
			default:    tap_of = 3'h0;
		endcase
	endfunction

	wire                step_adv   = AC_MODE && STEP_TICK;
	wire                step_wrap  = STEP_INDEX == `STEP_LAST;
	wire [`STEP_W-1:0]  next_step  = step_wrap ? `STEP_FIRST : STEP_INDEX + 4'h1;
	wire [2:0]          next_tap   = tap_of(next_step);

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			STEP_INDEX     <= `STEP_FIRST;
			TAP_SELECT     <= 3'h0;
			STEP_CARRY     <= 1'b0;
			QS_STEP_STROBE <= 1'b0;
		end else if (CE) begin
			STEP_CARRY     <= step_adv && step_wrap;
			QS_STEP_STROBE <= step_adv;
			if (step_adv) begin
				STEP_INDEX <= next_step;
				TAP_SELECT <= next_tap;
			end
		end
	end

	// ----------------------------------------------------------------------
	// 16 kHz frequency reference
	// ----------------------------------------------------------------------
	// locking by re-phasing the low stage keeps the loop digital; the cost is
	// a phase step of up to one 16 kHz cycle when the external edge moves
	wire ext_rise = EXT_REF && !ext_prev;
	wire relock   = EXT_REF_SELECT && ext_rise;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			freq_count <= '0;
			ext_prev   <= 1'b0;
		end else if (CE) begin
			ext_prev <= EXT_REF;
			if (relock)
				freq_count <= {freq_count[`FREQ_W-1:`LOCK_LOW_W], 8'h00};
			else if (xtal_tick)
				freq_count <= freq_count + 13'h0001;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			FREQ_REF_16K <= 1'b0;
			FREQ_REF_8K  <= 1'b0;
		end else if (CE) begin
			FREQ_REF_16K <= AC_MODE && freq_count[`TAP_16K_BIT];
			FREQ_REF_8K  <= AC_MODE && freq_count[`TAP_8K_BIT];
		end
	end

	// ----------------------------------------------------------------------
	// in-guard latch over the serial link
	// ----------------------------------------------------------------------
	inguard_latch u_latch (
		.clock        (CLOCK),
		.rst          (RST),
		.ce           (CE),
		.link_data    (LINK_DATA),
		.bit_valid    (LINK_BIT_VALID),
		.frame_start  (LINK_FRAME_START),
		.status_in    (STATUS_IN),
		.control_word (CONTROL_WORD),
		.status_out   (LINK_STATUS_OUT)
	);

	// ----------------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	// tap of the step half a period earlier, for the symmetry check
	wire [2:0] mirror_tap = tap_of(STEP_INDEX - 4'h5);

	sequence seq_match;
		CE && hit_match && !hit_overflow;
	endsequence

	sequence seq_space_begins;
		PULSE_RESET && !CHOP_MARK;
	endsequence

	AST_COUNT_ADVANCE: assert property (
		CE && xtal_tick |=> count == $past(count) + 25'h000_0001)
		else $error("counter did not advance on crystal tick");

	AST_THRESHOLD_LOAD: assert property (
		CE && THRESHOLD_LOAD |=> threshold == $past(THRESHOLD))
		else $error("threshold latch not loaded");

	AST_RESET_PULSE: assert property (
		seq_match |=> seq_space_begins)
		else $error("match did not give reset pulse and space");

	AST_SET_PULSE: assert property (
		CE && hit_overflow |=> PULSE_SET && CHOP_MARK)
		else $error("overflow did not give set pulse and mark");

	AST_MARK_HOLD: assert property (
		CE && !hit_match && !hit_overflow |=> $stable(CHOP_MARK))
		else $error("chopper state moved without a pulse");

	AST_POLARITY: assert property (
		CE && !AC_MODE && POLARITY_NEG |=> REF_INVERT)
		else $error("negative DC polarity did not invert reference");

	AST_TEN_STEPS: assert property (
		CE && step_adv && STEP_INDEX == `STEP_LAST |=> STEP_CARRY && STEP_INDEX == `STEP_FIRST)
		else $error("sequencer did not wrap after ten steps");

	AST_STEP_SYMMETRY: assert property (
		STEP_INDEX >= 4'h5 && STEP_INDEX <= `STEP_LAST |->
			TAP_SELECT[1:0] == mirror_tap[1:0]
			&& TAP_SELECT[2] == (mirror_tap[1:0] != 2'h0))
		else $error("tap table not symmetric");

	AST_STROBE_FOLLOWS: assert property (
		CE && step_adv |=> QS_STEP_STROBE ##0 STEP_INDEX != $past(STEP_INDEX))
		else $error("comparator strobe not tied to step advance");

endmodule

// ### sim/host_link_model.sv
// processor side of the isolated control link: sends 48-bit frames bit-serially
// assumes the caller sequences the frames; clock is the block's system clock
`timescale 1ns/1ps

module host_link_model (
	input  wire logic clock,
	input  wire logic status_out,
	output logic      link_data,
	output logic      bit_valid,
	output logic      frame_start
);
	logic [7:0] status_seen;

	initial begin
		link_data   = 1'b0;
		bit_valid   = 1'b0;
		frame_start = 1'b0;
		status_seen = 8'h00;
	end

	// whole word every frame, never only the changed fields; nbits < 48 cuts it short
	task automatic send_frame(input logic [47:0] word, input int nbits, input int gap);
		int i;
		@(posedge clock);
		#1;
		frame_start = 1'b1;
		@(posedge clock);
		#1;
		frame_start = 1'b0;
		for (i = 0; i < nbits; i++) begin
			// status bit i stands before data bit i is sent, msb first
			if (i < 8)
				status_seen = {status_seen[6:0], status_out};
			link_data = word[47 - i];
			bit_valid = 1'b1;
			@(posedge clock);
			#1;
			if (gap > 0 || i == nbits - 1) begin
				// a released line shows the inverse, not a held copy of the bit
				bit_valid = 1'b0;
				link_data = ~word[47 - i];
				repeat (gap) begin
					@(posedge clock);
					#1;
				end
			end
		end
	endtask
endmodule

// ### sim/test_mark_ref_timing.sv
// self-checking bench for the mark-period reference timing block
// assumes 50 MHz clock; crystal tick derived inside, so timings are windows
`timescale 1ns/1ps
`include "mark_ref_cfg.svh"

module test_mark_ref_timing;
	logic                 clock, rst, ce, thr_load, ac_mode, pol_neg, ext_sel, ext_ref;
	logic                 step_tick, link_data, bit_valid, frame_start;
	logic [`CNT_W-1:0]    threshold;
	logic [`STATUS_W-1:0] status_in;
	logic                 pulse_reset, pulse_set, chop_mark, ref_invert, step_carry;
	logic                 qs_strobe, freq_16k, freq_8k, status_out;
	logic [2:0]           tap_select;
	logic [`STEP_W-1:0]   step_index;
	logic [`LATCH_W-1:0]  control_word;
	int                   error_cnt, checks, n, k;
	localparam logic [2:0] tap_tbl [10] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h1,
		3'h0, 3'h5, 3'h6, 3'h6, 3'h5};

	mark_ref_timing u_mark_ref_timing (.CLOCK(clock), .RST(rst), .CE(ce),
		.THRESHOLD(threshold), .THRESHOLD_LOAD(thr_load), .AC_MODE(ac_mode),
		.POLARITY_NEG(pol_neg), .EXT_REF_SELECT(ext_sel), .EXT_REF(ext_ref),
		.STEP_TICK(step_tick), .LINK_DATA(link_data), .LINK_BIT_VALID(bit_valid),
		.LINK_FRAME_START(frame_start), .STATUS_IN(status_in), .PULSE_RESET(pulse_reset),
		.PULSE_SET(pulse_set), .CHOP_MARK(chop_mark), .REF_INVERT(ref_invert),
		.TAP_SELECT(tap_select), .STEP_INDEX(step_index), .STEP_CARRY(step_carry),
		.QS_STEP_STROBE(qs_strobe), .FREQ_REF_16K(freq_16k), .FREQ_REF_8K(freq_8k),
		.CONTROL_WORD(control_word), .LINK_STATUS_OUT(status_out));

	host_link_model u_host_link_model (.clock(clock), .status_out(status_out),
		.link_data(link_data), .bit_valid(bit_valid), .frame_start(frame_start));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_rng(input string what, input int lo, input int hi, input int v);
		checks++;
		if (v < lo || v > hi) begin
			error_cnt++;
			$display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, v);
		end
	endtask

	task automatic hang(input string what);
		error_cnt++;
		$display("FAIL %s expected done seen timeout", what);
		end_of_test();
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic cyc();
		@(posedge clock);
		#1;
	endtask

	task automatic do_reset();
		rst = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		rst = 1'b0;
	endtask

	// counts cycles until the selected frequency output reaches lvl
	task automatic wait_lvl(input int sel, input logic lvl, output int c);
		c = 0;
		while ((sel ? freq_8k : freq_16k) !== lvl) begin
			cyc();
			c++;
			if (c > 7000)
				hang("frequency edge");
		end
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_threshold();
		threshold = 25'h000_0005;
		thr_load  = 1'b1;
		do_reset();
		chk("idle word", 48'h0, control_word);
		chk("idle outputs", 48'h0, 48'({pulse_set, pulse_reset, chop_mark, step_index}));
		// sixth crystal tick meets count 5: about 6 x 12.2 cycles
		n = 0;
		while (pulse_reset !== 1'b1) begin
			cyc();
			n++;
			if (n > 300)
				hang("match pulse");
		end
		chk_rng("match delay", 70, 84, n);
		threshold = 25'h000_000A;
		cyc();
		chk("pulse width", 48'h0, {46'h0, pulse_reset, chop_mark});
		chk("no set pulse", 48'h0, 48'(pulse_set));
		n = 0;
		while (pulse_reset !== 1'b1) begin
			cyc();
			n++;
			if (n > 300)
				hang("reloaded match");
		end
		chk_rng("reloaded match delay", 55, 68, n);
		chk("space after match", 48'h0, 48'(chop_mark));
		$display("test threshold done");
	endtask

	task automatic t_polarity();
		for (k = 0; k < 4; k++) begin
			ac_mode = k[1];
			pol_neg = k[0];
			repeat (2) cyc();
			chk("reference invert", 48'(!k[1] && k[0]), 48'(ref_invert));
		end
		$display("test polarity done");
	endtask

	task automatic t_steps();
		ac_mode   = 1'b1;
		do_reset();
		step_tick = 1'b1;
		for (k = 1; k <= 10; k++) begin
			cyc();
			chk("step index", 48'(k % 10), 48'(step_index));
			chk("tap code", 48'(tap_tbl[k % 10]), 48'(tap_select));
			chk("step strobe", 48'h1, 48'(qs_strobe));
			chk("step carry", 48'(k == 10), 48'(step_carry));
		end
		ce = 1'b0;
		cyc();
		chk("frozen index", 48'h0, 48'(step_index));
		ce      = 1'b1;
		ac_mode = 1'b0;
		cyc();
		step_tick = 1'b0;
		chk("dc ignores tick", 48'h0, 48'({step_index, qs_strobe}));
		$display("test steps done");
	endtask

	task automatic t_freq();
		ac_mode = 1'b1;
		wait_lvl(0, 0, n);
		wait_lvl(0, 1, n);
		wait_lvl(0, 0, n);
		chk_rng("16k high time", 1550, 1575, n);
		wait_lvl(1, 1, n);
		wait_lvl(1, 0, n);
		chk_rng("8k high time", 3110, 3140, n);
		ext_sel = 1'b1;
		wait_lvl(0, 1, n);
		ext_ref = 1'b1;
		cyc();
		ext_ref = 1'b0;
		wait_lvl(0, 0, n);
		chk_rng("lock clears", 0, 3, n);
		wait_lvl(0, 1, n);
		chk_rng("relocked half period", 1548, 1575, n);
		ac_mode = 1'b0;
		repeat (3) cyc();
		chk("dc reference off", 48'h0, 48'({freq_16k, freq_8k}));
		$display("test frequency done");
	endtask

	task automatic t_link();
		status_in = 8'hA5;
		u_host_link_model.send_frame(48'hC3A5_0F1E_9B27, 48, 2);
		repeat (2) cyc();
		chk("control word", 48'hC3A5_0F1E_9B27, control_word);
		chk("status return", 48'hA5, 48'(u_host_link_model.status_seen));
		u_host_link_model.send_frame(48'h1234_5678_9ABC, 47, 0);
		repeat (3) cyc();
		chk("partial frame held", 48'hC3A5_0F1E_9B27, control_word);
		status_in = 8'h5A;
		u_host_link_model.send_frame(48'h1234_5678_9ABC, 48, 0);
		repeat (2) cyc();
		chk("restarted word", 48'h1234_5678_9ABC, control_word);
		chk("status back to back", 48'h5A, 48'(u_host_link_model.status_seen));
		$display("test link done");
	endtask

	initial begin
		error_cnt = 0;
		checks    = 0;
		{rst, ce, thr_load, ac_mode, pol_neg, ext_sel, ext_ref, step_tick} = 8'hC0;
		threshold = 25'h000_0000;
		status_in = 8'h00;
		t_threshold();
		t_polarity();
		t_steps();
		t_freq();
		t_link();
		end_of_test();
	end
endmodule
